// [hw/fcp_unit.sv]
// command interface, erase/program sequencer and protection for the flash array
`timescale 1ns/1ps
`default_nettype none
module fcp_unit
  import fcp_pkg::*;
#(
  parameter int AW           = 18,
  parameter int MAX_PULSES   = 16,
  parameter int WIPE_TMO_CYC = fcp_pkg::WIPE_TMO_CYC
) (
  // clock, enable and resets
  input  wire logic          clock,
  input  wire logic          ce,
  input  wire logic          sys_rst,
  input  wire logic          nv_por,
  // cpu access
  input  wire logic          cpu_wr,
  input  wire logic          cpu_rd,
  input  wire logic          cpu_from_flash,
  input  wire logic [AW-1:0] cpu_addr,
  input  wire logic [DW-1:0] cpu_wdata,
  output logic      [DW-1:0] cpu_rdata,
  output logic               cpu_rvalid,
  output logic               busy,
  // flash array
  output logic      [AW-1:0] arr_raddr,
  input  wire logic [DW-1:0] arr_rdata,
  output logic               arr_req,
  output logic      [1:0]    arr_op,
  output logic      [AW-1:0] arr_addr,
  output logic      [DW-1:0] arr_wdata,
  input  wire logic          arr_ack,
  input  wire logic          arr_ok
);
  // expiry is registered one edge late, so load one less to end on the count
  localparam logic [TMO_W-1:0] TMO_LOAD  = TMO_W'(WIPE_TMO_CYC - 1);
  localparam logic [TMO_W-1:0] SUSP_LOAD = TMO_W'(SUSP_MIN_CYC);
  localparam logic [PULSE_W-1:0] PULSE_LAST = PULSE_W'(MAX_PULSES - 1);

  if (AW < CMD_AW + 1) begin : g_bad_aw
    $error("fcp_unit: address too narrow");
  end
  if (WIPE_TMO_CYC < 2 || WIPE_TMO_CYC >= 2 ** TMO_W) begin : g_bad_tmo
    $error("fcp_unit: erase timeout out of range");
  end
  if (MAX_PULSES < 2 || MAX_PULSES >= 2 ** PULSE_W) begin : g_bad_pulses
    $error("fcp_unit: pulse limit out of range");
  end

  function automatic logic [3:0] blk_of(input logic [AW-1:0] a);
    blk_of = (a[AW-1 -: 4] > LAST_BLK) ? LAST_BLK : a[AW-1 -: 4];
  endfunction : blk_of

  fcp_state_e         state;
  fcp_state_e         next_state;
  fcp_state_e         home;
  logic [AW-1:0]      pgm_addr;
  logic [DW-1:0]      pgm_data;
  logic               pgm_chk;
  logic [NBLK-1:0]    sel;
  logic               susp_ctx;
  logic               bypass;
  logic [3:0]         cur_blk;
  logic               zero_phase;
  logic [PULSE_W-1:0] pulses;
  logic               ewfail;
  logic               arr_busy;
  logic               req_prog;
  logic               tog_a;
  logic               tog_b;
  logic               tmo_run;
  logic               tmo_exp;
  logic               susp_run;
  fcp_lock_if         lk ();

  // write decode
  wire [7:0] cmd_lo    = cpu_wdata[7:0];
  wire       at_a1     = cpu_addr[CMD_AW-1:0] == UNLOCK_ADDR1;
  wire       at_a2     = cpu_addr[CMD_AW-1:0] == UNLOCK_ADDR2;
  wire       wr_en1    = cpu_wr && at_a1 && cmd_lo == CODE_EN1;
  wire       wr_en2    = cpu_wr && at_a2 && cmd_lo == CODE_EN2;
  wire       wr_rst    = cpu_wr && cmd_lo == CODE_RESET;
  wire       wr_conf   = cpu_wr && cmd_lo == CODE_CONF;
  wire       wr_susp   = cpu_wr && cmd_lo == CODE_SUSP;
  wire       wr_chip   = cpu_wr && at_a1 && cmd_lo == CODE_CHIP;
  wire [3:0] wr_blk    = blk_of(cpu_addr);
  wire [NBLK-1:0] wr_onehot = NBLK'(1) << wr_blk;

  // engine decode
  wire code_locked = !lk.active[CODE_LOCK_POS];
  wire prog_bad    = |(pgm_data & ~arr_rdata);
  wire prog_locked = !lk.active[blk_of(pgm_addr)] && !bypass;
  wire prog_step   = state == S_PROG && pgm_chk && !arr_busy;
  wire prog_issue  = prog_step && !prog_bad && !prog_locked;
  wire prog_fail   = prog_step && (prog_bad || prog_locked);
  wire prog_ack    = arr_ack && req_prog;
  wire eng_ack     = arr_ack && !req_prog;
  wire eng_end     = cur_blk == BLK_END;
  wire eng_open    = sel[cur_blk] && (lk.active[cur_blk] || bypass);
  wire eng_step    = state == S_ERASE && !arr_busy && !eng_end;
  wire eng_issue   = eng_step && eng_open;
  wire eng_skip    = eng_step && !eng_open;
  wire eng_finish  = state == S_ERASE && !arr_busy && eng_end;
  wire eng_init    = state == S_ER5 && (wr_conf || wr_chip);
  wire take_pgm    = state == S_PGM_DATA && cpu_wr && !(susp_ctx && sel[wr_blk]);
  wire status_sel  = state inside {S_PROG, S_ERASE, S_TMO, S_SWAIT, S_FAIL}
                     || (state == S_SUSP && sel[blk_of(cpu_addr)]);
  wire req_open    = lk.active[blk_of(arr_addr)] || bypass;

  // status word: poll, toggles, fail, timeout
  wire poll_v = (state == S_SUSP) || (state == S_PROG && !pgm_data[ST_POLL]);
  wire [DW-1:0] stat_word = (DW'(poll_v) << ST_POLL) | (DW'(tog_a) << ST_TOGA)
                          | (DW'(state == S_FAIL) << ST_FAIL)
                          | (DW'(state != S_TMO) << ST_TMR)
                          | (DW'(tog_b) << ST_TOGB);
  wire [DW-1:0] rd_mux = status_sel ? stat_word
                       : (code_locked && !cpu_from_flash) ? CODE_TRAP : arr_rdata;

  assign home         = susp_ctx ? S_SUSP : S_READ;
  assign arr_raddr    = (state == S_PROG && pgm_chk) ? pgm_addr : cpu_addr;
  assign busy         = state inside {S_PROG, S_ERASE, S_TMO, S_SWAIT};
  assign lk.prog      = ce && state == S_PEN && cpu_wr && cmd_lo != CODE_BYPASS;
  assign lk.prog_data = cpu_wdata;

  always_comb begin
    next_state = state;
    unique case (state)
      S_READ:     if (wr_en1) next_state = S_EN1;
      S_EN1:      if (cpu_wr) next_state = wr_en2 ? S_EN2 : (wr_rst ? S_READ : home);
      S_EN2: begin
        if (cpu_wr) begin
          if (at_a1 && cmd_lo == CODE_PROG) next_state = S_PGM_DATA;
          else if (at_a1 && cmd_lo == CODE_ERASE_EN && !susp_ctx) next_state = S_ER3;
          else if (at_a1 && cmd_lo == CODE_PROT_EN && !susp_ctx) next_state = S_PEN;
          else next_state = wr_rst ? S_READ : home;
        end
      end
      S_PGM_DATA: if (cpu_wr) next_state = take_pgm ? S_PROG : home;
      S_PROG: begin
        if (prog_fail) next_state = S_FAIL;
        else if (prog_ack) next_state = arr_ok ? home : S_FAIL;
      end
      S_ER3:      if (cpu_wr) next_state = wr_en1 ? S_ER4 : S_READ;
      S_ER4:      if (cpu_wr) next_state = wr_en2 ? S_ER5 : S_READ;
      S_ER5: begin
        if (wr_conf) next_state = S_TMO;
        else if (wr_chip) next_state = S_ERASE;
        else if (cpu_wr) next_state = S_READ;
      end
      S_TMO: begin
        if (wr_conf) next_state = S_TMO;
        else if (wr_susp) next_state = S_SWAIT;
        else if (cpu_wr) next_state = S_READ;
        else if (tmo_exp) next_state = S_ERASE;
      end
      S_ERASE: begin
        if (wr_susp) next_state = S_SWAIT;
        else if (wr_rst) next_state = S_READ;
        else if (eng_finish) next_state = ewfail ? S_FAIL : S_READ;
      end
      S_SWAIT:    if (!susp_run && !arr_busy) next_state = S_SUSP;
      S_SUSP: begin
        if (cpu_wr && cmd_lo == CODE_RESUME) next_state = S_ERASE;
        else if (wr_en1) next_state = S_EN1;
        else if (wr_rst) next_state = S_READ;
      end
      S_PEN: begin
        if (cpu_wr) begin
          if (cmd_lo == CODE_BYPASS) next_state = S_BYP;
          else next_state = lk.err ? S_FAIL : S_READ;
        end
      end
      S_BYP:      if (cpu_wr) next_state = S_READ;
      S_FAIL:     if (wr_rst) next_state = S_READ;
      default:    next_state = S_READ;
    endcase
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      state    <= S_READ;
      susp_ctx <= 1'b0;
      bypass   <= 1'b0;
    end else if (ce) begin
      state    <= next_state;
      susp_ctx <= (next_state == S_SUSP) || (susp_ctx && !(next_state inside {S_READ, S_ERASE}));
      if (state == S_PEN && cpu_wr && cmd_lo == CODE_BYPASS) bypass <= 1'b1;
    end
  end

  // block selection for erase
  always_ff @(posedge clock) begin
    if (sys_rst) sel <= '0;
    else if (ce) begin
      if (next_state == S_READ) sel <= '0;
      else if (state == S_ER5 && wr_chip) sel <= '1;
      else if (state == S_ER5 && wr_conf) sel <= wr_onehot;
      else if (state == S_TMO && wr_conf) sel <= sel | wr_onehot;
    end
  end

  // erase engine walk over the selected blocks
  always_ff @(posedge clock) begin
    if (sys_rst || (ce && eng_init)) begin
      cur_blk    <= '0;
      zero_phase <= 1'b1;
      pulses     <= '0;
      ewfail     <= 1'b0;
    end else if (ce && eng_skip) begin
      cur_blk <= cur_blk + 4'h1;
    end else if (ce && eng_ack) begin
      if (zero_phase) zero_phase <= 1'b0;
      else if (arr_ok || pulses == PULSE_LAST) begin
        ewfail     <= ewfail || !arr_ok;
        cur_blk    <= cur_blk + 4'h1;
        zero_phase <= 1'b1;
        pulses     <= '0;
      end else pulses <= pulses + PULSE_W'(1);
    end
  end

  // array requests, one outstanding at a time
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      arr_req  <= 1'b0;
      arr_busy <= 1'b0;
      req_prog <= 1'b0;
      arr_op   <= OP_PROG;
      arr_addr <= '0;
      arr_wdata <= WORD_ERASED;
    end else if (ce) begin
      arr_req <= prog_issue || eng_issue;
      if (prog_issue || eng_issue) begin
        arr_busy  <= 1'b1;
        req_prog  <= prog_issue;
        arr_op    <= prog_issue ? OP_PROG : (zero_phase ? OP_ZERO : OP_ERASE);
        arr_addr  <= prog_issue ? pgm_addr : {cur_blk, {(AW-4){1'b0}}};
        arr_wdata <= prog_issue ? pgm_data : (zero_phase ? WORD_PREPROG : WORD_ERASED);
      end else if (arr_ack) arr_busy <= 1'b0;
    end
  end

  // latched program target
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      pgm_addr <= '0;
      pgm_data <= WORD_ERASED;
      pgm_chk  <= 1'b0;
    end else if (ce) begin
      if (take_pgm) begin
        pgm_addr <= cpu_addr;
        pgm_data <= cpu_wdata;
        pgm_chk  <= 1'b1;
      end else if (prog_issue || prog_fail) pgm_chk <= 1'b0;
    end
  end

  // read answer and toggle bits
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      cpu_rdata  <= '0;
      cpu_rvalid <= 1'b0;
      tog_a      <= 1'b0;
      tog_b      <= 1'b0;
    end else if (ce) begin
      cpu_rvalid <= cpu_rd;
      if (cpu_rd) cpu_rdata <= rd_mux;
      if (cpu_rd && status_sel) begin
        tog_a <= tog_a ^ (state != S_SUSP);
        tog_b <= ~tog_b;
      end
    end
  end

  fcp_timer #(.CW(TMO_W)) u_tmo (
    .clock    (clock),
    .ce       (ce),
    .sys_rst  (sys_rst),
    .start    (state inside {S_ER5, S_TMO} && wr_conf),
    .stop     (state == S_TMO && cpu_wr && !wr_conf),
    .load_val (TMO_LOAD),
    .running  (tmo_run),
    .expired  (tmo_exp)
  );

  fcp_timer #(.CW(TMO_W)) u_susp (
    .clock    (clock),
    .ce       (ce),
    .sys_rst  (sys_rst),
    .start    (state != S_SWAIT && next_state == S_SWAIT),
    .stop     (1'b0),
    .load_val (SUSP_LOAD),
    .running  (susp_run),
    .expired  ()
  );

  fcp_lockword u_lock (
    .clock   (clock),
    .ce      (ce),
    .sys_rst (sys_rst),
    .nv_por  (nv_por),
    .lk      (lk)
  );

  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);

  sequence s_erase_read;
    ce && cpu_rd && state == S_ERASE;
  endsequence

  chk_locked_refused: assert property (arr_req |-> req_open)
    else $error("array operation on a locked block");
  chk_code_trap: assert property (
    ce && cpu_rd && !status_sel && code_locked && !cpu_from_flash |=> cpu_rdata == CODE_TRAP)
    else $error("protected read did not return trap code");
  chk_zero_only: assert property (ce && prog_step && prog_bad |=> state == S_FAIL)
    else $error("zero to one programming not flagged");
  chk_bad_code: assert property (
    ce && state == S_ER3 && cpu_wr && !wr_en1 |=> state == S_READ)
    else $error("wrong coded cycle did not abort");
  chk_timeout_end: assert property (
    ce && state == S_TMO && tmo_exp && !cpu_wr |=> state == S_ERASE && stat_word[ST_TMR])
    else $error("timeout expiry did not start erase");
  chk_erase_toggle: assert property (
    s_erase_read |=> !cpu_rdata[ST_POLL] && tog_a != $past(tog_a))
    else $error("erase status read wrong");
  chk_preprog_first: assert property (arr_req && arr_op == OP_ERASE |-> !zero_phase)
    else $error("erase issued before preprogram");
  chk_erase_accepts: assert property (
    ce && state == S_ERASE && cpu_wr && !wr_susp && !wr_rst
    |=> state inside {S_ERASE, S_READ, S_FAIL})
    else $error("erase accepted a foreign command");
endmodule : fcp_unit
`default_nettype wire

// [hw/fcp_pkg.sv]
// constants, codes and states for the flash command and protection unit
package fcp_pkg;
  localparam int          DW            = 16;
  localparam int          CMD_AW        = 14;
  localparam int          NBLK          = 11;
  localparam int          TMO_W         = 16;
  localparam int          PULSE_W       = 8;
  localparam logic [13:0] UNLOCK_ADDR1  = 14'h1554;
  localparam logic [13:0] UNLOCK_ADDR2  = 14'h2aa8;
  localparam logic [7:0]  CODE_EN1      = 8'ha8;
  localparam logic [7:0]  CODE_EN2      = 8'h54;
  localparam logic [7:0]  CODE_RESET    = 8'hf0;
  localparam logic [7:0]  CODE_PROG     = 8'ha0;
  localparam logic [7:0]  CODE_ERASE_EN = 8'h80;
  localparam logic [7:0]  CODE_CONF     = 8'h30;
  localparam logic [7:0]  CODE_CHIP     = 8'h10;
  localparam logic [7:0]  CODE_SUSP     = 8'hb0;
  localparam logic [7:0]  CODE_RESUME   = 8'h30;
  localparam logic [7:0]  CODE_PROT_EN  = 8'hc0;
  localparam logic [7:0]  CODE_BYPASS   = 8'hc1;
  localparam logic [15:0] CODE_TRAP     = 16'h009b;
  localparam logic [15:0] WORD_ERASED   = 16'hffff;
  localparam logic [15:0] WORD_PREPROG  = 16'h0000;
  localparam logic [15:0] LOCK_INIT     = 16'hffff;
  localparam logic [15:0] LOCK_MASK     = 16'h87ff;
  localparam int          CODE_LOCK_POS = 15;
  localparam logic [3:0]  LAST_BLK      = 4'ha;
  localparam logic [3:0]  BLK_END       = 4'hb;
  localparam int          ST_POLL       = 7;
  localparam int          ST_TOGA       = 6;
  localparam int          ST_FAIL       = 5;
  localparam int          ST_TMR        = 3;
  localparam int          ST_TOGB       = 2;
  localparam logic [1:0]  OP_PROG       = 2'h0;
  localparam logic [1:0]  OP_ZERO       = 2'h1;
  localparam logic [1:0]  OP_ERASE      = 2'h2;
  localparam int          CLK_PERIOD_NS = 10;
  localparam int          WIPE_TMO_NS   = 96000;
  localparam int          WIPE_TMO_CYC  = WIPE_TMO_NS / CLK_PERIOD_NS;
  localparam int          SUSP_MIN_NS   = 100;
  localparam int          SUSP_MIN_CYC  = (SUSP_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  typedef enum logic [3:0] {
    S_READ, S_EN1, S_EN2, S_PGM_DATA, S_PROG, S_ER3, S_ER4, S_ER5,
    S_TMO, S_ERASE, S_SWAIT, S_SUSP, S_PEN, S_BYP, S_FAIL
  } fcp_state_e;
endpackage : fcp_pkg

// [hw/fcp_lock_if.sv]
// carrier between the sequencer and the protection word store
`timescale 1ns/1ps
`default_nettype none
interface fcp_lock_if;
  logic        prog;
  logic [15:0] prog_data;
  logic [15:0] stored;
  logic [15:0] active;
  logic        err;
  modport owner (input prog, input prog_data, output stored, output active, output err);
  modport user  (output prog, output prog_data, input stored, input active, input err);
endinterface : fcp_lock_if
`default_nettype wire

// [hw/fcp_timer.sv]
// loadable down-counter that pulses once when it runs out
`timescale 1ns/1ps
`default_nettype none
module fcp_timer #(
  parameter int CW = 16
) (
  // clock and control
  input  wire logic          clock,
  input  wire logic          ce,
  input  wire logic          sys_rst,
  // commands
  input  wire logic          start,
  input  wire logic          stop,
  input  wire logic [CW-1:0] load_val,
  // state
  output logic               running,
  output logic               expired
);
  logic [CW-1:0] count;

  if (CW < 2) begin : g_bad_width
    $error("fcp_timer: counter too narrow");
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      count   <= '0;
      running <= 1'b0;
      expired <= 1'b0;
    end else if (ce) begin
      expired <= 1'b0;
      if (start) begin
        count   <= load_val;
        running <= 1'b1;
      end else if (stop) begin
        running <= 1'b0;
      end else if (running) begin
        count   <= count - 1'b1;
        running <= (count != CW'(1));
        expired <= (count == CW'(1));
      end
    end
  end

  chk_timer_restart: assert property (@(posedge clock) disable iff (sys_rst)
    start && ce |=> running && count == $past(load_val))
    else $error("timer did not reload on start");
  chk_timer_end: assert property (@(posedge clock) disable iff (sys_rst)
    $rose(expired) |-> $past(count) == CW'(1) && !running)
    else $error("timer expired at wrong count");
endmodule : fcp_timer
`default_nettype wire

// [hw/fcp_lockword.sv]
// non-volatile protection word and its reset-time working copy
`timescale 1ns/1ps
`default_nettype none
module fcp_lockword
  import fcp_pkg::*;
(
  // clock and resets
  input  wire logic clock,
  input  wire logic ce,
  input  wire logic sys_rst,
  input  wire logic nv_por,
  // sequencer side
  fcp_lock_if.owner lk
);
  assign lk.err = |(~lk.stored & lk.prog_data & LOCK_MASK);

  always_ff @(posedge clock) begin
    if (nv_por)
      lk.stored <= LOCK_INIT;
    else if (ce && lk.prog)
      lk.stored <= lk.stored & (lk.prog_data | ~LOCK_MASK);
  end

  always_ff @(posedge clock) begin
    if (sys_rst)
      lk.active <= lk.stored;
  end

  chk_lock_no_rise: assert property (@(posedge clock) disable iff (nv_por)
    !$past(nv_por) |-> (lk.stored & ~$past(lk.stored)) == 16'h0000)
    else $error("protection bit returned to one");
  chk_active_at_reset: assert property (@(posedge clock) disable iff (sys_rst)
    !$past(sys_rst) |-> $stable(lk.active))
    else $error("protection copy changed outside reset");
endmodule : fcp_lockword
`default_nettype wire

// [dv/fcp_array_model.sv]
// behavioural flash array: async read, delayed acknowledge of word and block operations
`timescale 1ns/1ps
`default_nettype none
module fcp_array_model #(
  parameter int AW = 18
) (
  // clock
  input  wire logic          clock,
  // array port
  input  wire logic [AW-1:0] arr_raddr,
  output logic      [15:0]   arr_rdata,
  input  wire logic          arr_req,
  input  wire logic [1:0]    arr_op,
  input  wire logic [AW-1:0] arr_addr,
  input  wire logic [15:0]   arr_wdata,
  output logic               arr_ack,
  output logic               arr_ok,
  // test controls
  input  wire logic          bad_erase,
  input  wire logic [3:0]    lag
);
  logic [15:0] mem [2**AW];
  int          cnt;
  logic        ok;
  assign arr_rdata = mem[arr_raddr];
  initial begin
    foreach (mem[i]) mem[i] = 16'hffff;
    cnt = 0;
    arr_ack = 1'b0;
    arr_ok = 1'b0;
  end
  // an erase pulse leaves the block untouched when the test asks it to fail
  always @(posedge clock) begin
    arr_ack <= 1'b0;
    arr_ok <= 1'b0;
    if (arr_req) begin
      cnt <= lag + 1;
    end else if (cnt == 1) begin
      ok = !(bad_erase && arr_op == 2'h2);
      if (arr_op == 2'h0) begin
        mem[arr_addr] = arr_wdata;
      end else if (ok) begin
        for (int i = 0; i < 2**(AW-4); i++) mem[{arr_addr[AW-1:AW-4], i[AW-5:0]}] = arr_wdata;
      end
      arr_ack <= 1'b1;
      arr_ok <= ok;
      cnt <= 0;
    end else if (cnt > 1) begin
      cnt <= cnt - 1;
    end
  end
endmodule : fcp_array_model
`default_nettype wire

// [dv/tb.sv]
// self-checking bench for the flash command and protection unit
`timescale 1ns/1ps
`default_nettype none
`define ck(a, b) begin checks++; if ((a) !== (b)) begin n_fail++; \
  $display("[FAIL] %0t %h %h", $time, (a), (b)); end end
module tb
  import fcp_pkg::*;
;
  localparam logic [17:0] U1 = 18'h01554;
  localparam logic [17:0] U2 = 18'h02aa8;
  localparam logic [17:0] WA = 18'h00100;
  localparam logic [17:0] PA = 18'h00200;
  logic        clock, sys_rst, nv_por, cpu_wr, cpu_rd, ffl, bad, cpu_rvalid, busy;
  logic        arr_req, arr_ack, arr_ok;
  logic [1:0]  arr_op;
  logic [3:0]  lag;
  logic [17:0] ad, arr_raddr, arr_addr;
  logic [15:0] wd, q, s, cpu_rdata, arr_rdata, arr_wdata;
  int          n_fail, checks;
  fcp_unit #(.AW(18), .MAX_PULSES(4), .WIPE_TMO_CYC(20)) fcp_unit_inst (
    .clock(clock), .ce(1'b1), .sys_rst(sys_rst), .nv_por(nv_por), .cpu_wr(cpu_wr),
    .cpu_rd(cpu_rd), .cpu_from_flash(ffl), .cpu_addr(ad), .cpu_wdata(wd),
    .cpu_rdata(cpu_rdata), .cpu_rvalid(cpu_rvalid), .busy(busy), .arr_raddr(arr_raddr),
    .arr_rdata(arr_rdata), .arr_req(arr_req), .arr_op(arr_op), .arr_addr(arr_addr),
    .arr_wdata(arr_wdata), .arr_ack(arr_ack), .arr_ok(arr_ok));
  fcp_array_model #(.AW(18)) fcp_array_model_inst (
    .clock(clock), .arr_raddr(arr_raddr), .arr_rdata(arr_rdata), .arr_req(arr_req),
    .arr_op(arr_op), .arr_addr(arr_addr), .arr_wdata(arr_wdata), .arr_ack(arr_ack),
    .arr_ok(arr_ok), .bad_erase(bad), .lag(lag));
  task automatic results;
    if (n_fail == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : results
  task automatic wr(input logic [17:0] a, input logic [15:0] d);
    @(negedge clock);
    ad = a;
    wd = d;
    cpu_wr = 1'b1;
    @(negedge clock);
    cpu_wr = 1'b0;
  endtask : wr
  task automatic rd(input logic [17:0] a, output logic [15:0] d);
    @(negedge clock);
    ad = a;
    cpu_rd = 1'b1;
    @(negedge clock);
    cpu_rd = 1'b0;
    d = (cpu_rvalid === 1'b1) ? cpu_rdata : 16'hxxxx;
  endtask : rd
  task automatic en;
    wr(U1, 16'h00a8);
    wr(U2, 16'h0054);
  endtask : en
  task automatic pw(input logic [17:0] a, input logic [15:0] d);
    en();
    wr(U1, 16'h00a0);
    wr(a, d);
  endtask : pw
  task automatic er;
    en();
    wr(U1, 16'h0080);
    en();
  endtask : er
  task automatic wt;
    for (int i = 0; i < 3000 && busy !== 1'b0; i++) @(negedge clock);
    if (busy !== 1'b0) n_fail++;
  endtask : wt
  task automatic rst;
    sys_rst = 1'b1;
    repeat (8) @(negedge clock);
    sys_rst = 1'b0;
  endtask : rst
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  // nearly thirty times the expected length of the run
  initial begin
    #500000;
    n_fail++;
    results();
  end
  initial begin
    {cpu_wr, cpu_rd, ffl, bad, ad, wd, n_fail, checks} = '0;
    lag = 4'h8;
    nv_por = 1'b1;
    rst();
    nv_por = 1'b0;
    pw(WA, 16'h1234);
    rd(WA, q);
    `ck(q[ST_POLL], 1'b1)
    wt();
    rd(WA, q);
    `ck(q, 16'h1234)
    pw(WA, 16'h1235);
    rd(WA, q);
    `ck(q[ST_FAIL], 1'b1)
    wr(18'h0, 16'h00f0);
    rd(WA, q);
    `ck(q, 16'h1234)
    er();
    wr(18'h04000, 16'h0020);
    wr(18'h04000, 16'h0030);
    `ck(busy, 1'b0)
    pw(18'h04000, 16'h00ff);
    wt();
    er();
    wr(18'h04000, 16'h0030);
    repeat (15) @(negedge clock);
    wr(18'h08000, 16'h0030);
    repeat (10) @(negedge clock);
    rd(18'h0, q);
    `ck(q[ST_TMR], 1'b0)
    repeat (15) @(negedge clock);
    rd(18'h0, q);
    `ck(q[ST_TMR], 1'b1)
    `ck(q[ST_POLL], 1'b0)
    rd(18'h0, s);
    `ck(s[ST_TOGA], ~q[ST_TOGA])
    wt();
    rd(18'h04000, q);
    `ck(q, 16'hffff)
    er();
    wr(18'h08000, 16'h0030);
    repeat (25) @(negedge clock);
    wr(18'h0, 16'h00b0);
    repeat (20) @(negedge clock);
    rd(WA, q);
    `ck(q, 16'h1234)
    rd(18'h08000, q);
    rd(18'h08000, s);
    `ck(s[ST_TOGB], ~q[ST_TOGB])
    wr(18'h0, 16'h0030);
    `ck(busy, 1'b1)
    wt();
    er();
    wr(18'h08000, 16'h0030);
    wr(18'h0, 16'h00b0);
    repeat (20) @(negedge clock);
    rd(18'h08000, q);
    rd(18'h08000, s);
    `ck(s[ST_TOGB], ~q[ST_TOGB])
    wr(18'h0, 16'h00f0);
    rd(18'h08000, q);
    `ck(q, 16'hffff)
    bad = 1'b1;
    er();
    wr(18'h0c000, 16'h0030);
    wt();
    rd(18'h0c000, q);
    `ck(q[ST_FAIL], 1'b1)
    bad = 1'b0;
    wr(18'h0, 16'h00f0);
    repeat (1000) @(negedge clock);
    rd(18'h0c000, q);
    `ck(q, 16'h0000)
    en();
    wr(U1, 16'h00c0);
    wr(18'h1, 16'h7ffe);
    pw(PA, 16'h5555);
    wt();
    rd(PA, q);
    `ck(q, 16'h5555)
    rst();
    rd(PA, q);
    `ck(q, CODE_TRAP)
    ffl = 1'b1;
    rd(PA, q);
    `ck(q, 16'h5555)
    pw(PA, 16'h1111);
    rd(PA, q);
    `ck(q[ST_FAIL], 1'b1)
    wr(18'h0, 16'h00f0);
    en();
    wr(U1, 16'h00c0);
    wr(U1, 16'h00c1);
    wr(18'h0, 16'h00f0);
    pw(PA, 16'h1111);
    wt();
    rd(PA, q);
    `ck(q, 16'h1111)
    rst();
    pw(18'h04000, 16'h00ff);
    wt();
    er();
    wr(U1, 16'h0010);
    `ck(busy, 1'b1)
    wr(U1, 16'h00a8);
    `ck(busy, 1'b1)
    wt();
    rd(PA, q);
    `ck(q, 16'h1111)
    rd(18'h04000, q);
    `ck(q, 16'hffff)
    en();
    wr(U1, 16'h00c0);
    wr(18'h1, 16'hffff);
    rd(18'h0, q);
    `ck(q[ST_FAIL], 1'b1)
    results();
  end
endmodule : tb
`default_nettype wire
